// *** rtl/pce_port_ctrl.sv ***
// Port C and port E pin control with register file and alternate pin routing
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
module pce_port_ctrl
  import pce_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input  wire logic                  ref_clk,          // 125 MHz system clock
  input  wire logic                  rst_n,            // Async reset, active low
  input  wire logic [PCE_ADDR_W-1:0] reg_addr,         // Register index
  input  wire logic [7:0]            reg_wdata,        // Write data
  input  wire logic                  reg_wr,           // Write strobe
  input  wire logic                  reg_rd,           // Read strobe
  output logic      [7:0]            reg_rdata,        // Read data, cycle after strobe
  input  wire logic [PORT_W-1:0]     c_pad_in,         // Port C pad levels
  output logic      [PORT_W-1:0]     c_pad_out,        // Port C pad drive levels
  output logic      [PORT_W-1:0]     c_pad_oe_n,       // Port C driver enables, low drives
  input  wire logic                  e_pad_in,         // Port E pin level
  output logic                       e_pullup_en,      // Weak pull-up on port E pin
  output logic                       mclr_reset,       // Master clear request, level
  output logic                       vpp_sense,        // Programming voltage level seen
  input  wire logic [PORT_W-1:0]     periph_out,       // Peripheral outputs on port C
  input  wire logic [PORT_W-1:0]     periph_oe_n,      // Peripheral enables, low drives
  input  wire logic                  second_capture_compare_pwm_out,         // Second capture unit output
  input  wire logic                  second_capture_compare_pwm_oe_n,        // Second capture unit enable, low drives
  output logic                       second_capture_compare_pwm_in,          // Second capture unit input
  input  wire logic                  b3_pad_in,        // Port B bit 3 pad level
  output logic                       b3_ccp_out,       // Capture output toward port B bit 3
  output logic                       b3_ccp_oe_n,      // Its enable, low drives
  output logic                       b3_ccp_en         // Port B bit 3 owned by capture unit
);
  // The register map gives one byte per port, so only the eight-bit width is served
  if (PORT_W != 8) begin : g_width_check
    $error("pce_port_ctrl serves an eight-bit port only");
  end

  typedef struct packed {
    logic [1:0]        rst_sync;
    logic [PORT_W-1:0] c_latch;
    logic [PORT_W-1:0] c_dir;
    logic [PORT_W-1:0] c_analog;
    logic [PORT_W-1:0] periph_en;
    logic              ccp_sel;
    logic [1:0]        e_cfg;
    logic [7:0]        rdata;
  } pce_state_s;

  pce_state_s state_reg;
  pce_state_s state_next;
  logic [PORT_W-1:0] c_read;
  logic [PORT_W-1:0] cell_periph_en;
  logic [PORT_W-1:0] cell_periph_out;
  logic [PORT_W-1:0] cell_periph_oe_n;
  logic              rst_int_n;
  logic              ccp_on_c;
  logic              e_read;

  assign rst_int_n = state_reg.rst_sync[1];
  assign ccp_on_c  = state_reg.ccp_sel;

  // Capture unit takes port C bit 1 when selected, otherwise port B bit 3
  always_comb begin
    cell_periph_en   = state_reg.periph_en;
    cell_periph_out  = periph_out;
    cell_periph_oe_n = periph_oe_n;
    cell_periph_en[PCE_CCP_C_BIT]   = ccp_on_c;
    cell_periph_out[PCE_CCP_C_BIT]  = second_capture_compare_pwm_out;
    cell_periph_oe_n[PCE_CCP_C_BIT] = second_capture_compare_pwm_oe_n;
  end

  // Port B bit 3 keeps the capture unit only while the select points away from port C
  always_comb begin
    b3_ccp_en   = 1'b1;
    b3_ccp_out  = second_capture_compare_pwm_out;
    b3_ccp_oe_n = second_capture_compare_pwm_oe_n;
    second_capture_compare_pwm_in     = b3_pad_in;
    if (ccp_on_c) begin
      b3_ccp_en   = 1'b0;
      b3_ccp_oe_n = 1'b1;
      second_capture_compare_pwm_in     = c_pad_in[PCE_CCP_C_BIT];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pin
      pce_pin_cell u_cell (
        .latch_bit   (state_reg.c_latch[gi]),
        .dir_bit     (state_reg.c_dir[gi]),
        .analog_bit  (state_reg.c_analog[gi]),
        .periph_en   (cell_periph_en[gi]),
        .periph_out  (cell_periph_out[gi]),
        .periph_oe_n (cell_periph_oe_n[gi]),
        .pad_in      (c_pad_in[gi]),
        .pad_out     (c_pad_out[gi]),
        .pad_oe_n    (c_pad_oe_n[gi]),
        .read_bit    (c_read[gi])
      );
    end
  endgenerate

  // Port E pin role follows the configuration bits
  always_comb begin
    e_read      = e_pad_in;
    e_pullup_en = 1'b0;
    mclr_reset  = 1'b0;
    vpp_sense   = 1'b0;
    if (state_reg.e_cfg[PCE_MCLR_BIT]) begin
      // Master clear role: reads blank, the weak pull-up holds the pin inactive
      e_read      = 1'b0;
      e_pullup_en = 1'b1;
      mclr_reset  = ~e_pad_in;
    end
    if (state_reg.e_cfg[PCE_VPP_BIT]) begin
      vpp_sense = e_pad_in;
    end
  end

  function automatic logic [7:0] read_mux(input pce_state_s s, input logic [PORT_W-1:0] cr,
                                          input logic [2:0] a, input logic er);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      PCE_OFS_C_LEVELS:  v = cr;
      PCE_OFS_C_DIR:     v = s.c_dir;
      PCE_OFS_E_LEVEL: begin
        // Only the input-only pin exists on this port; the other bits stay zero
        v[PCE_E_PIN_BIT] = er;
      end
      PCE_OFS_E_DIR: begin
        v = PCE_E_DIR_VALUE;
      end
      PCE_OFS_ALT_FUNC: begin
        v[PCE_CCP_SEL_BIT] = s.ccp_sel;
      end
      PCE_OFS_C_ANALOG:  v = s.c_analog;
      PCE_OFS_PERIPH_EN: v = s.periph_en;
      PCE_OFS_E_CONFIG:  v = {6'h00, s.e_cfg};
    endcase
    return v;
  endfunction

  // One register write; the read-only indices leave the state untouched
  function automatic pce_state_s apply_write(input pce_state_s s, input logic [2:0] a,
                                             input logic [7:0] d);
    pce_state_s n;
    n = s;
    unique case (a)
      PCE_OFS_C_LEVELS: begin
        // A byte write addresses every bit, so nothing of the pin levels survives the merge
        n.c_latch = d;
      end
      PCE_OFS_C_DIR: begin
        n.c_dir = d;
      end
      PCE_OFS_ALT_FUNC: begin
        n.ccp_sel = d[PCE_CCP_SEL_BIT];
      end
      PCE_OFS_C_ANALOG: begin
        n.c_analog = d;
      end
      PCE_OFS_PERIPH_EN: begin
        n.periph_en = d;
      end
      PCE_OFS_E_CONFIG: begin
        n.e_cfg = d[1:0];
      end
      PCE_OFS_E_LEVEL, PCE_OFS_E_DIR: begin
        // Input-only port: neither its level nor its direction can be written
        n = s;
      end
    endcase
    return n;
  endfunction

  // Values held while the released reset is still inside the two-stage synchroniser
  function automatic pce_state_s held_in_reset(input pce_state_s s);
    pce_state_s n;
    n           = s;
    n.c_latch   = PCE_C_LATCH_RST;
    n.c_dir     = PCE_C_DIR_RST;
    n.c_analog  = PCE_ANALOG_RST;
    n.periph_en = '0;
    n.ccp_sel   = 1'b0;
    n.e_cfg     = 2'h0;
    n.rdata     = 8'h00;
    return n;
  endfunction

  always_comb begin
    state_next          = state_reg;
    state_next.rst_sync = {state_reg.rst_sync[0], 1'b1};
    state_next.rdata    = 8'h00;
    if (reg_rd) begin
      state_next.rdata = read_mux(state_reg, c_read, reg_addr, e_read);
    end
    // The read samples state_reg, not the written state, so the order of these two steps is free
    if (reg_wr) begin
      state_next = apply_write(state_next, reg_addr, reg_wdata);
    end
    if (!rst_int_n) begin
      state_next = held_in_reset(state_next);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg           <= '0;
      state_reg.c_dir     <= PCE_C_DIR_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
endmodule // pce_port_ctrl

// *** rtl/pce_pkg.sv ***
// Package of register offsets, field positions and reset values for the port C/E pin block
package pce_pkg;
  localparam int         PCE_ADDR_W        = 3;
  localparam logic [2:0] PCE_OFS_C_LEVELS  = 3'h0;
  localparam logic [2:0] PCE_OFS_C_DIR     = 3'h1;
  localparam logic [2:0] PCE_OFS_E_LEVEL   = 3'h2;
  localparam logic [2:0] PCE_OFS_E_DIR     = 3'h3;
  localparam logic [2:0] PCE_OFS_ALT_FUNC  = 3'h4;
  localparam logic [2:0] PCE_OFS_C_ANALOG  = 3'h5;
  localparam logic [2:0] PCE_OFS_PERIPH_EN = 3'h6;
  localparam logic [2:0] PCE_OFS_E_CONFIG  = 3'h7;
  localparam int         PCE_E_PIN_BIT     = 3;
  localparam int         PCE_CCP_SEL_BIT   = 0;
  localparam int         PCE_CCP_C_BIT     = 1;
  localparam int         PCE_MCLR_BIT      = 0;
  localparam int         PCE_VPP_BIT       = 1;
  localparam logic [7:0] PCE_C_DIR_RST     = 8'hff;
  localparam logic [7:0] PCE_C_LATCH_RST   = 8'h00;
  localparam logic [7:0] PCE_ANALOG_RST    = 8'h00;
  localparam logic [7:0] PCE_E_DIR_VALUE   = 8'h08;
endpackage

// *** rtl/pce_pin_cell.sv ***
// One bidirectional pin of the eight-bit port with peripheral override and analog blanking
`timescale 1ns/1ns
module pce_pin_cell
  import pce_pkg::*;
(
  input  wire logic latch_bit,    // General purpose output latch
  input  wire logic dir_bit,      // 1 = input, driver off
  input  wire logic analog_bit,   // Pin used as analog input
  input  wire logic periph_en,    // Peripheral owns the pin
  input  wire logic periph_out,   // Peripheral output level
  input  wire logic periph_oe_n,  // Peripheral enable, low drives
  input  wire logic pad_in,       // Sampled pad level
  output logic      pad_out,      // Pad drive level
  output logic      pad_oe_n,     // Pad driver enable, low drives
  output logic      read_bit      // Level seen by a port read
);
  always_comb begin
    pad_out  = periph_en ? periph_out : latch_bit;
    pad_oe_n = periph_en ? periph_oe_n : dir_bit;
    read_bit = analog_bit ? 1'b0 : pad_in;
  end
endmodule // pce_pin_cell

// *** tb/pce_props.sv ***
// Checker on the port C/E pin block ports
`timescale 1ns/1ns
module pce_props
  import pce_pkg::*;
(
  input wire logic       ref_clk,     // Clock
  input wire logic       rst_n,       // Reset
  input wire logic [2:0] reg_addr,    // Index
  input wire logic [7:0] reg_wdata,   // Write data
  input wire logic       reg_wr,      // Write
  input wire logic       reg_rd,      // Read
  input wire logic [7:0] reg_rdata,   // Read data
  input wire logic [7:0] c_pad_in,    // C pads
  input wire logic [7:0] c_pad_oe_n,  // C enables
  input wire logic       e_pad_in,    // E pin
  input wire logic       e_pullup_en, // Pull-up
  input wire logic       mclr_reset,  // Clear request
  input wire logic       b3_ccp_oe_n  // B3 enable
);
  logic [7:0] dir_reg, ana_reg, alt_reg, pen_reg, cfg_reg;
  logic       known_reg;
  // Reset values of indices 4, 6 and 7 are open, so they count only once index 7 is written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {dir_reg, ana_reg, alt_reg, pen_reg, cfg_reg, known_reg} <= {PCE_C_DIR_RST, PCE_ANALOG_RST, 25'h0};
    end else if (reg_wr) begin
      case (reg_addr)
        PCE_OFS_C_DIR:     dir_reg <= reg_wdata;
        PCE_OFS_C_ANALOG:  ana_reg <= reg_wdata;
        PCE_OFS_ALT_FUNC:  alt_reg <= reg_wdata;
        PCE_OFS_PERIPH_EN: pen_reg <= reg_wdata;
        PCE_OFS_E_CONFIG:  {cfg_reg, known_reg} <= {reg_wdata, 1'b1};
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  c_read_a: assert property (reg_rd && reg_addr == PCE_OFS_C_LEVELS |=>
    reg_rdata == ($past(c_pad_in) & ~ana_reg)) else $error("port C read wrong");
  c_dir_a: assert property (known_reg && pen_reg == 8'h00 && !alt_reg[PCE_CCP_SEL_BIT] |->
    c_pad_oe_n == dir_reg) else $error("driver enable not direction");
  e_dir_a: assert property (reg_rd && reg_addr == PCE_OFS_E_DIR |=> reg_rdata == PCE_E_DIR_VALUE)
    else $error("port E direction wrong");
  e_unimpl_a: assert property (reg_rd && reg_addr == PCE_OFS_E_LEVEL |=> (reg_rdata & 8'hf7) == 8'h00)
    else $error("unimplemented bit set");
  mclr_read_a: assert property (reg_rd && reg_addr == PCE_OFS_E_LEVEL && known_reg && cfg_reg[PCE_MCLR_BIT]
    |=> reg_rdata == 8'h00) else $error("clear pin not blanked");
  mclr_pin_a: assert property (known_reg && cfg_reg[PCE_MCLR_BIT] |->
    e_pullup_en && mclr_reset == !e_pad_in) else $error("clear pin wrong");
  ccp_c1_a: assert property (known_reg && alt_reg[PCE_CCP_SEL_BIT] |-> b3_ccp_oe_n)
    else $error("B3 driven with capture on C1");
  c_read_c: cover property (reg_rd && reg_addr == PCE_OFS_C_LEVELS && ana_reg != 8'h00);
  mclr_c: cover property (known_reg && cfg_reg[PCE_MCLR_BIT] && !e_pad_in);
  ccp_c: cover property (known_reg && alt_reg[PCE_CCP_SEL_BIT]);
endmodule // pce_props
bind pce_port_ctrl pce_props props_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .c_pad_in, .c_pad_oe_n, .e_pad_in, .e_pullup_en, .mclr_reset, .b3_ccp_oe_n);

// *** tb/pce_board.sv ***
// Board model of the port C and port E pins
`timescale 1ns/1ns
module pce_board (
  input  wire logic [7:0] c_pad_out,   // Block drive
  input  wire logic [7:0] c_pad_oe_n,  // Block enables
  input  wire logic [7:0] ext,         // Board drive
  output logic      [7:0] c_pad_in,    // Pin levels
  input  wire logic       e_ext,       // Board level on E
  input  wire logic       e_drive,     // Board drives E
  input  wire logic       e_pullup_en, // Weak pull-up
  output logic            e_pad_in     // E pin level
);
  assign c_pad_in = (c_pad_out & ~c_pad_oe_n) | (ext & c_pad_oe_n);
  // A floating pin without pull-up must not keep its last level
  assign e_pad_in = e_drive ? e_ext : (e_pullup_en | ~e_ext);
endmodule // pce_board

// *** tb/port_c_e_pin_control_test.sv ***
// Self-checking bench of the port C/E pin block
`timescale 1ns/1ns
module port_c_e_pin_control_test;
  import pce_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, e_ext, e_drive, e_pullup_en, mclr_reset, vpp_sense, e_pad_in;
  logic second_capture_compare_pwm_out, second_capture_compare_pwm_oe_n, second_capture_compare_pwm_in, b3_pad_in, b3_ccp_out, b3_ccp_oe_n, b3_ccp_en;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, c_pad_in, c_pad_out, c_pad_oe_n, periph_out, periph_oe_n, ext;
  int failures, tests_run, cyc, dir, lat, ana;
  pce_port_ctrl dut_u (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .c_pad_in,
    .c_pad_out, .c_pad_oe_n, .e_pad_in, .e_pullup_en, .mclr_reset, .vpp_sense, .periph_out, .periph_oe_n,
    .second_capture_compare_pwm_out, .second_capture_compare_pwm_oe_n, .second_capture_compare_pwm_in, .b3_pad_in, .b3_ccp_out, .b3_ccp_oe_n, .b3_ccp_en);
  pce_board board_u (.c_pad_out, .c_pad_oe_n, .ext, .c_pad_in, .e_ext, .e_drive, .e_pullup_en, .e_pad_in);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ext, e_ext, e_drive, periph_out, second_capture_compare_pwm_out, b3_pad_in} = '0;
    {periph_oe_n, second_capture_compare_pwm_oe_n} = '1;
    {failures, tests_run, cyc} = '0;
    dir = $urandom(22);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(PCE_OFS_C_DIR, PCE_C_DIR_RST);
    wr(PCE_OFS_PERIPH_EN, 8'h00);
    wr(PCE_OFS_ALT_FUNC, 8'h00);
    wr(PCE_OFS_E_CONFIG, 8'h00);
    for (int i = 0; i < 8; i++) begin
      {dir, lat, ana} = {$urandom % 256, $urandom % 256, $urandom % 256};
      @(posedge ref_clk) ext <= 8'($urandom);
      wr(PCE_OFS_C_ANALOG, 8'(ana));
      wr(PCE_OFS_C_LEVELS, 8'(lat));
      wr(PCE_OFS_C_DIR, 8'(dir));
      chk(c_pad_oe_n, 8'(dir));
      chk(c_pad_out & ~c_pad_oe_n, 8'(lat & ~dir));
      rd(PCE_OFS_C_LEVELS, 8'(((lat & ~dir) | (int'(ext) & dir)) & ~ana));
      rd(PCE_OFS_C_DIR, 8'(dir));
      rd(PCE_OFS_C_ANALOG, 8'(ana));
    end
    for (int m = 0; m < 6; m++) begin
      @(posedge ref_clk) {e_drive, e_ext} <= {1'b1, m > 2};
      wr(PCE_OFS_E_CONFIG, 8'(m % 3));
      wr(PCE_OFS_E_DIR, 8'h00);
      rd(PCE_OFS_E_DIR, PCE_E_DIR_VALUE);
      rd(PCE_OFS_E_LEVEL, (m > 2 && m % 3 != 1) ? 8'h08 : 8'h00);
      chk({e_pullup_en, mclr_reset, vpp_sense}, 8'({m % 3 == 1, m == 1, m == 5}));
    end
    // Released pin in the clear role must float up on the pull-up, not hold the board level
    @(posedge ref_clk) e_drive <= 1'b0;
    wr(PCE_OFS_E_CONFIG, 8'h01);
    chk({e_pad_in, e_pullup_en, mclr_reset}, 8'h06);
    rd(PCE_OFS_E_LEVEL, 8'h00);
    wr(PCE_OFS_C_DIR, 8'h00);
    for (int s = 0; s < 2; s++) begin
      @(posedge ref_clk) {second_capture_compare_pwm_oe_n, second_capture_compare_pwm_out, b3_pad_in} <= 3'($urandom);
      wr(PCE_OFS_ALT_FUNC, 8'(s));
      rd(PCE_OFS_ALT_FUNC, 8'(s));
      if (s == 1) begin
        chk({c_pad_out[1], c_pad_oe_n[1], second_capture_compare_pwm_in}, {second_capture_compare_pwm_out, second_capture_compare_pwm_oe_n, c_pad_in[1]});
        chk({b3_ccp_oe_n, b3_ccp_en}, 8'h02);
      end else begin
        chk({b3_ccp_out, b3_ccp_oe_n, b3_ccp_en, second_capture_compare_pwm_in}, {second_capture_compare_pwm_out, second_capture_compare_pwm_oe_n, 1'b1, b3_pad_in});
      end
    end
    @(posedge ref_clk) {periph_out, periph_oe_n} <= {8'($urandom), 8'h00};
    wr(PCE_OFS_ALT_FUNC, 8'h00);
    wr(PCE_OFS_PERIPH_EN, 8'h30);
    wr(PCE_OFS_C_LEVELS, ~periph_out);
    wr(PCE_OFS_C_DIR, 8'h30);
    chk(c_pad_oe_n, 8'h00);
    chk(c_pad_out & 8'h30, periph_out & 8'h30);
    report_and_stop();
  end
endmodule // port_c_e_pin_control_test
